// ---- crap_pkg.sv ----
// Behaviour
// - Status registers are read-only and show live state of what they report.
// - Identification and revision registers return fixed hard-wired values.
// - Control registers read back the last written value; core events never change them.
// - Soft reset returns every control register to its default value.
// - Writing one to a pulse register bit gives a single-cycle pulse.
// - Pulse register bits always read as zero.
// - Each alarm bit latches its core event until software clears it.
// - An alarm bit clears only when one is written to it; the code also clears every alarm bit on soft reset.
// - All alarm and interrupt status bits reset to zero.
// - Interrupt status bit is the OR of its enabled lower-level bits.
// - An enable bit at one lets its alarm propagate upward.
// - An enable bit at zero masks propagation; the alarm still sets.
// - Every register is reached through the on-chip system bus.
// - Lock protects all writes except to the scratch pad register; the code also leaves both lock bytes writable.
// - The lock register is sixteen bits, readable and writable.
// - Protected writes are accepted only while the lock holds 0x0580.
// - A write denied by the lock sets an error flag.
// - The lock register resets to 0x0000, so the map starts locked.
// - Unused bits, unused addresses and write-only bits read as zero.
// - Map holds generic, device and eight equally spaced channel blocks.
// - The core map sits at base offset 0x30000 on the system bus.
// - Generic block pulse register bit zero issues a global reset command.
package crap_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int N_CH = 8;
  localparam logic [17:0] CORE_BASE = 18'h30000;
  localparam logic [7:0] A_REV = 8'h00;
  localparam logic [7:0] A_ID_LSB = 8'h01;
  localparam logic [7:0] A_ID_MSB = 8'h02;
  localparam logic [7:0] A_SCRATCH = 8'h03;
  localparam logic [7:0] A_LOCK_MSB = 8'h04;
  localparam logic [7:0] A_LOCK_LSB = 8'h05;
  localparam logic [7:0] A_GRST = 8'h06;
  localparam logic [7:0] A_ERR = 8'h07;
  localparam logic [7:0] A_DEV_CTRL = 8'h08;
  localparam logic [7:0] A_DEV_ALARM = 8'h09;
  localparam logic [7:0] A_DEV_EN = 8'h0a;
  localparam logic [7:0] A_CH_SUM = 8'h0b;
  localparam logic [7:0] A_CH_SUM_EN = 8'h0c;
  localparam logic [7:0] A_TOP_SUM = 8'h0d;
  localparam logic [7:0] A_DEV_STAT = 8'h0e;
  localparam logic [3:0] CH_FIRST = 4'h1;
  localparam logic [3:0] CH_LAST = 4'h8;
  localparam logic [3:0] CH_CTRL = 4'h0;
  localparam logic [3:0] CH_STAT = 4'h1;
  localparam logic [3:0] CH_ALARM = 4'h2;
  localparam logic [3:0] CH_EN = 4'h3;
  localparam logic [3:0] CH_PULSE = 4'h4;
  localparam int GRST_BIT = 0;
  localparam logic [15:0] LOCK_KEY = 16'h0580;
  localparam logic [15:0] LOCK_RST = 16'h0000;
  localparam logic [7:0] CREG_RST = 8'h00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] ALARM_RST = 8'h00;
endpackage

// ---- crap_alarm_reg.sv ----
`timescale 1ns/1ps
module crap_alarm_reg #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic soft_rst,
  input wire logic clr_wr,
  input wire logic [W-1:0] clr_data,
  input wire logic [W-1:0] event_in,
  output logic [W-1:0] alarm_q
);
  logic [W-1:0] alarm_d;

  // An event in the same cycle as its clear keeps the bit set.
  always_comb begin
    alarm_d = alarm_q;
    if (clr_wr) begin
      alarm_d = alarm_d & ~clr_data;
    end
    alarm_d = alarm_d | event_in;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alarm_q <= W'(crap_pkg::ALARM_RST);
    end else if (clk_en) begin
      if (soft_rst) begin
        alarm_q <= W'(crap_pkg::ALARM_RST);
      end else begin
        alarm_q <= alarm_d;
      end
    end
  end

  AST_ALARM_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n || !clk_en)
    !soft_rst && !clr_wr |=> (alarm_q & $past(alarm_q)) == $past(alarm_q))
    else $error("alarm bit dropped without a clear");
  AST_ALARM_SET_WINS: assert property (@(posedge clk_sys) disable iff (!reset_n || !clk_en)
    !soft_rst && (event_in != '0) |=> (alarm_q & $past(event_in)) == $past(event_in))
    else $error("event lost against a clear");
endmodule // crap_alarm_reg

// ---- crap_chan_regs.sv ----
`timescale 1ns/1ps
module crap_chan_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic soft_rst,
  input wire logic sel,
  input wire logic wr_ok,
  input wire logic [3:0] offset,
  input wire logic [7:0] wdata,
  input wire logic [7:0] status_in,
  input wire logic [7:0] event_in,
  output logic [7:0] ctrl_q,
  output logic [7:0] pulse_q,
  output logic [7:0] rdata,
  output logic summary
);
  logic [7:0] en_q;
  logic [7:0] alarm_q;
  logic wr_hit;

  assign wr_hit = sel && wr_ok;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= crap_pkg::CREG_RST;
    end else if (clk_en) begin
      if (soft_rst) begin
        ctrl_q <= crap_pkg::CREG_RST;
      end else if (wr_hit && offset == crap_pkg::CH_CTRL) begin
        ctrl_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= crap_pkg::CREG_RST;
    end else if (clk_en) begin
      if (soft_rst) begin
        en_q <= crap_pkg::CREG_RST;
      end else if (wr_hit && offset == crap_pkg::CH_EN) begin
        en_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulse_q <= 8'h00;
    end else if (clk_en) begin
      pulse_q <= (wr_hit && offset == crap_pkg::CH_PULSE && !soft_rst) ? wdata : 8'h00;
    end
  end

  crap_alarm_reg #(.W(8)) u_alarm (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .soft_rst(soft_rst),
    .clr_wr(wr_hit && offset == crap_pkg::CH_ALARM),
    .clr_data(wdata),
    .event_in(event_in),
    .alarm_q(alarm_q)
  );

  // Masked alarms still latch; only the upward path is gated.
  assign summary = |(alarm_q & en_q);

  always_comb begin
    rdata = 8'h00;
    case (offset)
      crap_pkg::CH_CTRL: rdata = ctrl_q;
      crap_pkg::CH_STAT: rdata = status_in;
      crap_pkg::CH_ALARM: rdata = alarm_q;
      crap_pkg::CH_EN: rdata = en_q;
      default: rdata = 8'h00;
    endcase
  end

  AST_CH_MASK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (alarm_q & en_q) == 8'h00 |-> !summary)
    else $error("masked alarm reached the summary");
endmodule // crap_chan_regs

// ---- crap_core_regs.sv ----
`timescale 1ns/1ps
module crap_core_regs #(
  parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value.
  parameter logic [7:0] ID_LSB_CODE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] ID_MSB_CODE = 8'ha5 // Arbitrary value.
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [17:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_ack,
  output logic write_denied,
  output logic global_reset_pulse,
  output logic [7:0] dev_ctrl,
  input wire logic [7:0] dev_status_in,
  input wire logic [7:0] dev_event_in,
  input wire logic [63:0] ch_status_in,
  input wire logic [63:0] ch_event_in,
  output logic [63:0] ch_ctrl,
  output logic [63:0] ch_pulse,
  output logic irq_summary
);
  // All status and event inputs come from core logic on clk_sys, so no
  // synchroniser stands in front of them.

  ////////////////////////////////////////////////////////////////////////////
  localparam int N = crap_pkg::N_CH;
  logic [7:0] a;
  logic hit;
  logic wr_req;
  logic unlocked;
  logic exempt;
  logic wr_ok;
  logic wr_deny;
  logic ch_hit;
  logic [3:0] ch_blk;
  logic [2:0] ch_idx;
  logic soft_rst;
  logic [15:0] lock_q;
  logic [7:0] scratch_q;
  logic [7:0] dev_ctrl_q;
  logic [7:0] dev_en_q;
  logic [7:0] ch_sum_en_q;
  logic [7:0] dev_alarm_q;
  logic [0:0] err_q;
  logic grst_q;
  logic [7:0] ch_sum;
  logic [7:0] ch_rdata [N];
  logic [7:0] rd_mux;

  assign a = bus_addr[7:0];
  assign hit = bus_addr[17:8] == crap_pkg::CORE_BASE[17:8];
  assign wr_req = clk_en && bus_wr && hit;
  assign unlocked = lock_q == crap_pkg::LOCK_KEY;
  // The lock itself must stay writable, or the map could never be opened.
  assign exempt = (a == crap_pkg::A_SCRATCH) || (a == crap_pkg::A_LOCK_MSB) ||
                  (a == crap_pkg::A_LOCK_LSB);
  assign wr_ok = wr_req && (unlocked || exempt);
  assign wr_deny = wr_req && !unlocked && !exempt;
  assign ch_blk = a[7:4];
  assign ch_hit = (ch_blk >= crap_pkg::CH_FIRST) && (ch_blk <= crap_pkg::CH_LAST);
  assign ch_idx = 3'(ch_blk - crap_pkg::CH_FIRST);
  assign soft_rst = grst_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lock_q <= crap_pkg::LOCK_RST;
    end else if (clk_en) begin
      if (soft_rst) begin
        lock_q <= crap_pkg::LOCK_RST;
      end else if (wr_ok && a == crap_pkg::A_LOCK_MSB) begin
        lock_q[15:8] <= bus_wdata;
      end else if (wr_ok && a == crap_pkg::A_LOCK_LSB) begin
        lock_q[7:0] <= bus_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scratch_q <= crap_pkg::SCRATCH_RST;
    end else if (clk_en) begin
      if (soft_rst) begin
        scratch_q <= crap_pkg::SCRATCH_RST;
      end else if (wr_ok && a == crap_pkg::A_SCRATCH) begin
        scratch_q <= bus_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dev_ctrl_q <= crap_pkg::CREG_RST;
    end else if (clk_en) begin
      if (soft_rst) begin
        dev_ctrl_q <= crap_pkg::CREG_RST;
      end else if (wr_ok && a == crap_pkg::A_DEV_CTRL) begin
        dev_ctrl_q <= bus_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dev_en_q <= crap_pkg::CREG_RST;
      ch_sum_en_q <= crap_pkg::CREG_RST;
    end else if (clk_en) begin
      if (soft_rst) begin
        dev_en_q <= crap_pkg::CREG_RST;
        ch_sum_en_q <= crap_pkg::CREG_RST;
      end else if (wr_ok && a == crap_pkg::A_DEV_EN) begin
        dev_en_q <= bus_wdata;
      end else if (wr_ok && a == crap_pkg::A_CH_SUM_EN) begin
        ch_sum_en_q <= bus_wdata;
      end
    end
  end

  // Pulse bit lives one cycle, then the soft reset it causes clears it too.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      grst_q <= 1'b0;
    end else if (clk_en) begin
      grst_q <= wr_ok && a == crap_pkg::A_GRST && bus_wdata[crap_pkg::GRST_BIT] && !soft_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  crap_alarm_reg #(.W(8)) u_dev_alarm (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .soft_rst(soft_rst),
    .clr_wr(wr_ok && a == crap_pkg::A_DEV_ALARM),
    .clr_data(bus_wdata),
    .event_in(dev_event_in),
    .alarm_q(dev_alarm_q)
  );

  // The error flag is cleared like any alarm, so clearing it needs the key.
  crap_alarm_reg #(.W(1)) u_err (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .soft_rst(soft_rst),
    .clr_wr(wr_ok && a == crap_pkg::A_ERR),
    .clr_data(bus_wdata[0:0]),
    .event_in(wr_deny),
    .alarm_q(err_q)
  );

  for (genvar g = 0; g < N; g++) begin : g_ch
    crap_chan_regs u_ch (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .soft_rst(soft_rst),
      .sel(ch_hit && ch_idx == 3'(g)),
      .wr_ok(wr_ok),
      .offset(a[3:0]),
      .wdata(bus_wdata),
      .status_in(ch_status_in[g*8 +: 8]),
      .event_in(ch_event_in[g*8 +: 8]),
      .ctrl_q(ch_ctrl[g*8 +: 8]),
      .pulse_q(ch_pulse[g*8 +: 8]),
      .rdata(ch_rdata[g]),
      .summary(ch_sum[g])
    );
  end

  // Two consolidation levels: channel summaries, then one top bit.
  assign irq_summary = |(ch_sum & ch_sum_en_q) || |(dev_alarm_q & dev_en_q);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_mux = 8'h00;
    if (hit) begin
      case (a)
        crap_pkg::A_REV: rd_mux = REV_CODE;
        crap_pkg::A_ID_LSB: rd_mux = ID_LSB_CODE;
        crap_pkg::A_ID_MSB: rd_mux = ID_MSB_CODE;
        crap_pkg::A_SCRATCH: rd_mux = scratch_q;
        crap_pkg::A_LOCK_MSB: rd_mux = lock_q[15:8];
        crap_pkg::A_LOCK_LSB: rd_mux = lock_q[7:0];
        crap_pkg::A_GRST: rd_mux = 8'h00;
        crap_pkg::A_ERR: rd_mux = {7'h00, err_q};
        crap_pkg::A_DEV_CTRL: rd_mux = dev_ctrl_q;
        crap_pkg::A_DEV_ALARM: rd_mux = dev_alarm_q;
        crap_pkg::A_DEV_EN: rd_mux = dev_en_q;
        crap_pkg::A_CH_SUM: rd_mux = ch_sum;
        crap_pkg::A_CH_SUM_EN: rd_mux = ch_sum_en_q;
        crap_pkg::A_TOP_SUM: rd_mux = {7'h00, irq_summary};
        crap_pkg::A_DEV_STAT: rd_mux = dev_status_in;
        default: rd_mux = ch_hit ? ch_rdata[ch_idx] : 8'h00;
      endcase
    end
  end

  // Data is presented in processor-port order; a fabric master swaps it.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 8'h00;
    end else if (clk_en) begin
      bus_rdata <= bus_rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
    end else if (clk_en) begin
      bus_ack <= bus_rd || bus_wr;
    end
  end

  assign write_denied = err_q[0];
  assign global_reset_pulse = grst_q;
  assign dev_ctrl = dev_ctrl_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n || !clk_en);

  AST_LOCK_SOFT_RST: assert property (soft_rst |=> lock_q == crap_pkg::LOCK_RST)
    else $error("lock not cleared by soft reset");
  AST_DENY_FLAG: assert property (wr_deny && !soft_rst |=> write_denied)
    else $error("denied write did not raise the error flag");
  AST_DENY_KEEPS: assert property (wr_deny && a == crap_pkg::A_DEV_CTRL && !soft_rst
    |=> $stable(dev_ctrl_q))
    else $error("denied write changed a control register");
  AST_CREG_WRITE: assert property (unlocked && wr_req && a == crap_pkg::A_DEV_CTRL && !soft_rst
    |=> dev_ctrl_q == $past(bus_wdata))
    else $error("control register missed an unlocked write");
  AST_CREG_HOLD: assert property (!(wr_req && a == crap_pkg::A_DEV_CTRL) && !soft_rst
    |=> $stable(dev_ctrl_q))
    else $error("control register changed without a write");
  AST_CREG_SOFT_RST: assert property (soft_rst |=> dev_ctrl_q == 8'h00 && dev_en_q == 8'h00)
    else $error("control register survived soft reset");
  AST_GRST_PULSE: assert property (wr_ok && a == crap_pkg::A_GRST && bus_wdata[crap_pkg::GRST_BIT]
    && !soft_rst |=> global_reset_pulse ##1 !global_reset_pulse)
    else $error("global reset is not a single pulse");
  AST_PULSE_READ: assert property (bus_rd && hit && a == crap_pkg::A_GRST |=> bus_rdata == 8'h00)
    else $error("pulse register read nonzero");
  AST_ID_FIXED: assert property (bus_rd && hit && a == crap_pkg::A_REV |=> bus_rdata == REV_CODE)
    else $error("revision register not fixed");
  AST_UNMAPPED: assert property (bus_rd && hit && a > crap_pkg::A_DEV_STAT && !ch_hit
    |=> bus_rdata == 8'h00)
    else $error("unused address read nonzero");
  AST_SCRATCH_OPEN: assert property (wr_req && a == crap_pkg::A_SCRATCH && !soft_rst
    |=> scratch_q == $past(bus_wdata))
    else $error("scratch pad rejected a write");
  AST_TOP_MASK: assert property ((dev_en_q == 8'h00) && (ch_sum_en_q == 8'h00) |-> !irq_summary)
    else $error("masked alarm propagated to the top");
  AST_ALARM_RESET: assert property (@(posedge clk_sys) $rose(reset_n)
    |-> dev_alarm_q == 8'h00 && err_q == 1'b0)
    else $error("alarm not zero after reset");

  // The answer is registered, so every check of it looks one enabled edge after the request.
  AST_ACK_FOLLOWS: assert property (
    (bus_rd || bus_wr) |=> bus_ack)
    else $error("request not acknowledged");
  AST_ACK_IDLE: assert property (
    !(bus_rd || bus_wr) |=> !bus_ack)
    else $error("acknowledge without a request");
  AST_RDATA_IDLE: assert property (
    !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data outside a read answer");
  AST_ID_LSB: assert property (
    bus_rd && hit && a == crap_pkg::A_ID_LSB |=> bus_rdata == ID_LSB_CODE)
    else $error("identification low byte not fixed");
  AST_ID_MSB: assert property (
    bus_rd && hit && a == crap_pkg::A_ID_MSB |=> bus_rdata == ID_MSB_CODE)
    else $error("identification high byte not fixed");
  AST_STAT_LIVE: assert property (
    bus_rd && hit && a == crap_pkg::A_DEV_STAT |=> bus_rdata == $past(dev_status_in))
    else $error("status read is not the live value");
  AST_OFF_BASE_RD: assert property (
    bus_rd && !hit |=> bus_rdata == 8'h00)
    else $error("read outside the core map returned data");
  AST_OFF_BASE_WR: assert property (
    bus_wr && !hit && !soft_rst |=> $stable(lock_q) && $stable(dev_ctrl_q))
    else $error("write outside the core map changed a register");

  // The lock bytes stay open while locked; everything else that a denied write touches must hold.
  AST_LOCK_LSB_OPEN: assert property (
    wr_req && a == crap_pkg::A_LOCK_LSB && !soft_rst |=> lock_q[7:0] == $past(bus_wdata))
    else $error("lock low byte missed a write");
  AST_LOCK_MSB_OPEN: assert property (
    wr_req && a == crap_pkg::A_LOCK_MSB && !soft_rst |=> lock_q[15:8] == $past(bus_wdata))
    else $error("lock high byte missed a write");
  AST_LOCK_HOLD: assert property (
    !(wr_req && (a == crap_pkg::A_LOCK_MSB || a == crap_pkg::A_LOCK_LSB)) && !soft_rst |=> $stable(lock_q))
    else $error("lock changed without a write");
  AST_GRST_LOCKED: assert property (
    wr_req && !unlocked && a == crap_pkg::A_GRST |=> !global_reset_pulse)
    else $error("global reset issued while locked");
  AST_DENY_EN: assert property (
    wr_deny && !soft_rst |=> $stable(dev_en_q) && $stable(ch_sum_en_q))
    else $error("denied write changed an enable register");
  AST_CH_WRITE_LOCKED: assert property (
    wr_deny && ch_hit && a[3:0] == crap_pkg::CH_CTRL && !soft_rst |=> $stable(ch_ctrl))
    else $error("denied write changed a channel control register");
  AST_ERR_CLEAR: assert property (
    unlocked && wr_req && a == crap_pkg::A_ERR && bus_wdata[0] && !soft_rst |=> !write_denied)
    else $error("error flag not cleared by writing one");

  // Consolidation is checked from the rule side, not by repeating the OR expression.
  AST_DEV_EN_WRITE: assert property (
    unlocked && wr_req && a == crap_pkg::A_DEV_EN && !soft_rst |=> dev_en_q == $past(bus_wdata))
    else $error("device enable missed an unlocked write");
  AST_SUM_EN_WRITE: assert property (
    unlocked && wr_req && a == crap_pkg::A_CH_SUM_EN && !soft_rst |=> ch_sum_en_q == $past(bus_wdata))
    else $error("summary enable missed an unlocked write");
  AST_SCRATCH_HOLD: assert property (
    !(wr_req && a == crap_pkg::A_SCRATCH) && !soft_rst |=> $stable(scratch_q))
    else $error("scratch pad changed without a write");
  AST_TOP_CH: assert property (
    (ch_sum & ch_sum_en_q) != 8'h00 |-> irq_summary)
    else $error("enabled channel summary did not reach the top");
  AST_TOP_DEV: assert property (
    (dev_alarm_q & dev_en_q) != 8'h00 |-> irq_summary)
    else $error("enabled device alarm did not reach the top");
  AST_SOFT_RST_ALARMS: assert property (
    soft_rst |=> dev_alarm_q == 8'h00 && !write_denied && scratch_q == crap_pkg::SCRATCH_RST)
    else $error("soft reset left an alarm or the scratch pad set");
  AST_RESET_OUTS: assert property (
    $rose(reset_n) |-> !bus_ack && bus_rdata == 8'h00 && lock_q == crap_pkg::LOCK_RST)
    else $error("outputs not idle after reset");
  AST_PULSE_SINGLE: assert property (
    global_reset_pulse |=> !global_reset_pulse)
    else $error("global reset pulse longer than one cycle");

  COV_UNLOCK_WRITE: cover property (unlocked && wr_req && a == crap_pkg::A_DEV_CTRL);
  COV_DENIED: cover property (wr_deny);
  COV_GRST: cover property (global_reset_pulse);
  COV_CH_IRQ: cover property (|ch_sum && irq_summary);
  COV_DEV_IRQ: cover property ((dev_alarm_q & dev_en_q) != 8'h00 && irq_summary);
endmodule // crap_core_regs

// ---- crap_bus_master.sv ----
`timescale 1ns/1ps
module crap_bus_master (
  input wire logic clk_sys,
  output logic [17:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_ack
);
  initial begin
    bus_addr = 18'h00000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The strobe stands for one cycle only, because the core takes a request on every edge that
  // sees it high; holding it longer would write twice. Data is kept in processor-port byte order.
  task automatic access(input logic [17:0] addr, input logic wr, input logic [7:0] data,
                        output logic [7:0] rdata, output logic ack);
    @(negedge clk_sys);
    bus_addr = addr;
    bus_wr = wr;
    bus_rd = !wr;
    bus_wdata = wr ? data : ~bus_wdata;
    @(posedge clk_sys);
    @(negedge clk_sys);
    ack = bus_ack;
    rdata = bus_rdata;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    // Released lines carry the inverse of their last value so nothing stale looks valid.
    bus_wdata = ~bus_wdata;
    bus_addr = ~bus_addr;
  endtask
endmodule // crap_bus_master

// ---- test_core_register_access_protection.sv ----
`timescale 1ns/1ps
module test_core_register_access_protection;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [17:0] bus_addr;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic bus_ack;
  logic write_denied;
  logic global_reset_pulse;
  logic [7:0] dev_ctrl;
  logic [7:0] dev_status_in = 8'h00;
  logic [7:0] dev_event_in = 8'h00;
  logic [63:0] ch_status_in = 64'h0;
  logic [63:0] ch_event_in = 64'h0;
  logic [63:0] ch_ctrl;
  logic [63:0] ch_pulse;
  logic irq_summary;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  crap_core_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .write_denied(write_denied), .global_reset_pulse(global_reset_pulse), .dev_ctrl(dev_ctrl),
    .dev_status_in(dev_status_in), .dev_event_in(dev_event_in), .ch_status_in(ch_status_in),
    .ch_event_in(ch_event_in), .ch_ctrl(ch_ctrl), .ch_pulse(ch_pulse), .irq_summary(irq_summary));

  crap_bus_master master (.clk_sys(clk_sys), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    master.access({10'h300, a}, 1'b1, d, r, k);
    chk(k, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic k;
    master.access({10'h300, a}, 1'b0, 8'h00, r, k);
    chk(k, 1'b1);
    chk(r, exp);
  endtask

  // Runs well under the ceiling; reaching it means the bus or a wait has hung.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a;
    logic [7:0] r;
    logic k;
    for (int g = 0; g < 8; g++) begin
      ch_status_in[8*g+:8] = 8'(8'h40 + g);
    end
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    rd(8'h00, 8'h01);
    rd(8'h01, 8'h5a);
    rd(8'h02, 8'ha5);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h0f, 8'h00);
    @(negedge clk_sys);
    dev_status_in = 8'h3c;
    rd(8'h0e, 8'h3c);
    dev_status_in = 8'hc3;
    rd(8'h0e, 8'hc3);
    wr(8'h08, 8'haa);
    chk(write_denied, 1'b1);
    chk(dev_ctrl, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h07, 8'h01);
    wr(8'h03, 8'h5a);
    rd(8'h03, 8'h5a);
    wr(8'h04, 8'h05);
    wr(8'h05, 8'h80);
    rd(8'h04, 8'h05);
    rd(8'h05, 8'h80);
    wr(8'h07, 8'h01);
    chk(write_denied, 1'b0);
    wr(8'h08, 8'haa);
    chk(dev_ctrl, 8'haa);
    @(negedge clk_sys);
    dev_event_in = 8'hff;
    @(negedge clk_sys);
    dev_event_in = 8'h00;
    rd(8'h08, 8'haa);
    rd(8'h09, 8'hff);
    wr(8'h09, 8'h0f);
    rd(8'h09, 8'hf0);
    wr(8'h0a, 8'h10);
    chk(irq_summary, 1'b1);
    wr(8'h0a, 8'h0f);
    chk(irq_summary, 1'b0);
    rd(8'h0a, 8'h0f);
    rd(8'h09, 8'hf0);
    wr(8'h09, 8'hff);
    // An event seen only while the clock enable is low must not latch.
    @(negedge clk_sys);
    clk_en = 1'b0;
    dev_event_in = 8'h01;
    @(negedge clk_sys);
    clk_en = 1'b1;
    dev_event_in = 8'h00;
    rd(8'h09, 8'h00);
    master.access(18'h20008, 1'b0, 8'h00, r, k);
    chk(r, 8'h00);
    master.access(18'h20008, 1'b1, 8'h55, r, k);
    chk(dev_ctrl, 8'haa);
    for (int g = 0; g < 8; g++) begin
      a = 8'((g + 1) * 16);
      wr(a, 8'(8'h11 * (g + 1)));
      chk(ch_ctrl[8*g+:8], 8'(8'h11 * (g + 1)));
      rd(a, 8'(8'h11 * (g + 1)));
      rd(a + 8'h01, 8'(8'h40 + g));
      wr(a + 8'h04, 8'h81);
      chk(ch_pulse[8*g+:8], 8'h81);
      @(negedge clk_sys);
      chk(ch_pulse, 64'h0);
      rd(a + 8'h04, 8'h00);
      rd(a + 8'h05, 8'h00);
    end
    @(negedge clk_sys);
    ch_event_in[16] = 1'b1;
    @(negedge clk_sys);
    ch_event_in[16] = 1'b0;
    rd(8'h32, 8'h01);
    rd(8'h0b, 8'h00);
    wr(8'h33, 8'h01);
    rd(8'h0b, 8'h04);
    chk(irq_summary, 1'b0);
    wr(8'h0c, 8'h04);
    chk(irq_summary, 1'b1);
    rd(8'h0d, 8'h01);
    rd(8'h0c, 8'h04);
    wr(8'h32, 8'h00);
    rd(8'h32, 8'h01);
    wr(8'h32, 8'h01);
    rd(8'h32, 8'h00);
    chk(irq_summary, 1'b0);
    wr(8'h06, 8'h01);
    chk(global_reset_pulse, 1'b1);
    @(negedge clk_sys);
    chk(global_reset_pulse, 1'b0);
    chk(dev_ctrl, 8'h00);
    chk(ch_ctrl, 64'h0);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h08, 8'h77);
    chk(write_denied, 1'b1);
    chk(dev_ctrl, 8'h00);
    wr(8'h10, 8'h33);
    chk(ch_ctrl, 64'h0);
    wr(8'h06, 8'h01);
    chk(global_reset_pulse, 1'b0);
    give_verdict();
  end
endmodule // test_core_register_access_protection
